// ==== verilog/per_router_top.sv ====
// peripheral event router with axi4-lite register slave
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`default_nettype none
// Operation
// - 32 dma request outputs, each picks one of four events, 128 events total.
// - first 16 selected requests also drive universal timer block triggers in the muxed variant; the direct variant holds them low.
// - every event is edge detected, then routed to its channel and gated by the channel enable.
// - same-domain events pass without added wait cycles.
// - foreign-domain events are synchronised into core clock when the channel's async bit is set.
// - direct variant maps event i straight to request channel i.
// - each channel has enable, readable handshake status, selectable request type.
// - request held until dma acknowledge or channel disable; dma acknowledges each accepted request.
module per_router_top #(
    parameter bit MUXED = 1'b1
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [per_pkg::PER_NUM_EVT-1:0] evt_in,
    input wire logic [per_pkg::PER_NUM_CH-1:0] dma_ack,
    output logic [per_pkg::PER_NUM_CH-1:0] dma_req,
    output logic [per_pkg::PER_NUM_CH*per_pkg::PER_TYPE_W-1:0] dma_req_type,
    output logic [per_pkg::PER_NUM_TRIG-1:0] timer_trig,
    input wire logic [per_pkg::PER_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [per_pkg::PER_DATA_W-1:0] s_axi_wdata,
    input wire logic [per_pkg::PER_STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [per_pkg::PER_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [per_pkg::PER_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import per_pkg::*;

    typedef struct packed {
        per_cfg_type [PER_NUM_CH-1:0] cfg;
        logic [PER_NUM_CH-1:0] req;
        logic [PER_NUM_TRIG-1:0] trig;
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [PER_ADDR_W-1:0] awaddr;
        logic [PER_DATA_W-1:0] wdata;
        logic [PER_STRB_W-1:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [PER_DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } per_top_type;

    per_top_type q;
    per_top_type d;
    logic [PER_NUM_EVT-1:0] ev_direct;
    logic [PER_NUM_EVT-1:0] ev_sync;
    logic [PER_NUM_CH-1:0] fire;
    logic [PER_NUM_CH-1:0] sw_hit;
    logic [PER_NUM_CH-1:0] en_vec;

    // ==========================================
    // event conditioning
    genvar gi;
    generate
        for (gi = 0; gi < PER_NUM_EVT; gi++) begin : g_evt
            per_event_cond u_cond (
                .core_clk(core_clk),
                .srst(srst),
                .evt(evt_in[gi]),
                .direct_rise(ev_direct[gi]),
                .sync_rise(ev_sync[gi])
            );
        end
    endgenerate

    // ==========================================
    // next state
    always_comb begin
        logic [PER_IDX_W-1:0] widx;
        logic [PER_IDX_W-1:0] ridx;
        logic wr_cfg;
        logic rd_cfg;
        logic rd_stat;
        logic [PER_DATA_W-1:0] rd;
        logic rise;
        int src;
        widx = q.awaddr[PER_IDX_LSB +: PER_IDX_W];
        ridx = s_axi_araddr[PER_IDX_LSB +: PER_IDX_W];
        wr_cfg = (q.awaddr >= PER_CFG_BASE) && (q.awaddr < PER_STATUS_ADDR);
        rd_cfg = (s_axi_araddr >= PER_CFG_BASE) && (s_axi_araddr < PER_STATUS_ADDR);
        rd_stat = s_axi_araddr[PER_ADDR_W-1:PER_IDX_LSB] == PER_STATUS_ADDR[PER_ADDR_W-1:PER_IDX_LSB];
        rd = '0;
        rise = 1'b0;
        src = 0;
        d = q;
        sw_hit = '0;
        // write channel capture, either order
        if (s_axi_awvalid && q.awready) begin
            d.aw_got = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            d.w_got = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        // register write once both halves are held
        if (q.aw_got && q.w_got) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = wr_cfg ? PER_RESP_OKAY : PER_RESP_SLVERR;
            if (wr_cfg && q.wstrb[PER_CFG_LANE]) begin
                d.cfg[widx] = per_cfg_type'(q.wdata[PER_CFG_W-1:0]);
            end
            if (wr_cfg && q.wstrb[PER_SW_LANE]) begin
                sw_hit[widx] = q.wdata[PER_SW_BIT];
            end
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        // read channel
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arready) begin
            if (rd_cfg) begin
                rd[PER_CFG_W-1:0] = q.cfg[ridx];
                rd[PER_STAT_BIT] = q.req[ridx];
            end else if (rd_stat) begin
                rd = q.req;
            end
            d.rvalid = 1'b1;
            d.rdata = rd;
            d.rresp = (rd_cfg || rd_stat) ? PER_RESP_OKAY : PER_RESP_SLVERR;
        end
        d.awready = ~d.aw_got & ~d.bvalid;
        d.wready = ~d.w_got & ~d.bvalid;
        d.arready = ~d.rvalid;
        // event selection, gating and handshake
        for (int i = 0; i < PER_NUM_CH; i++) begin
            if (MUXED) begin
                src = i * PER_NUM_SEL + int'(q.cfg[i].sel);
            end else begin
                src = i;
            end
            rise = q.cfg[i].async ? ev_sync[src] : ev_direct[src];
            fire[i] = q.cfg[i].en & (rise | sw_hit[i]);
            en_vec[i] = q.cfg[i].en;
            // new event wins over acknowledge
            d.req[i] = q.cfg[i].en & (fire[i] | (q.req[i] & ~dma_ack[i]));
        end
        for (int t = 0; t < PER_NUM_TRIG; t++) begin
            d.trig[t] = MUXED ? fire[t] : 1'b0;
        end
    end

    // ==========================================
    // registers
    always_ff @(posedge core_clk) begin
        if (srst) begin
            q <= '0;
            for (int i = 0; i < PER_NUM_CH; i++) begin
                q.cfg[i] <= PER_CFG_RST;
            end
        end else begin
            q <= d;
        end
    end

    // ==========================================
    // outputs
    assign dma_req = q.req;
    assign timer_trig = q.trig;
    generate
        for (gi = 0; gi < PER_NUM_CH; gi++) begin : g_type
            assign dma_req_type[gi*PER_TYPE_W +: PER_TYPE_W] = q.cfg[gi].rtype;
        end
    endgenerate
    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;

    // ==========================================
    // assertions
    logic [PER_NUM_CH-1:0] hold_v;
    logic [PER_NUM_CH-1:0] not_en;
    assign hold_v = dma_req & ~dma_ack & en_vec;
    assign not_en = ~en_vec;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_rd_bad;
        s_rd_take ##0 (s_axi_araddr >= PER_STATUS_ADDR + 12'h004);
    endsequence

    property p_req_hold;
        1 |=> (($past(hold_v) & ~dma_req) == '0);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped without ack");

    property p_fire_sets;
        (|fire) |=> (($past(fire) & ~dma_req) == '0);
    endproperty
    a_fire_sets: assert property (p_fire_sets) else $error("event did not raise request");

    property p_gate;
        1 |=> ((dma_req & $past(not_en)) == '0);
    endproperty
    a_gate: assert property (p_gate) else $error("request on disabled channel");

    property p_trig_req;
        (timer_trig & ~dma_req[PER_NUM_TRIG-1:0]) == '0;
    endproperty
    a_trig_req: assert property (p_trig_req) else $error("timer trigger without request");

    property p_wr_resp;
        s_wr_both |=> ##1 s_axi_bvalid;
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write response late");

    property p_rd_resp;
        s_rd_take |=> s_axi_rvalid;
    endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("read data late");

    property p_rd_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data not held");

    property p_rd_bad;
        s_rd_bad |=> s_axi_rresp == PER_RESP_SLVERR;
    endproperty
    a_rd_bad: assert property (p_rd_bad) else $error("unmapped read not refused");

    property p_type_out;
        !(q.aw_got && q.w_got) |=> $stable(dma_req_type);
    endproperty
    a_type_out: assert property (p_type_out) else $error("type output changed without write");
endmodule
`default_nettype wire

// ==== verilog/per_pkg.sv ====
// constants and types shared by the event router files
`default_nettype none
package per_pkg;
    // ==========================================
    // sizes
    localparam int PER_NUM_CH = 32;
    localparam int PER_NUM_SEL = 4;
    localparam int PER_NUM_EVT = 128;
    localparam int PER_NUM_TRIG = 16;
    localparam int PER_SEL_W = 2;
    localparam int PER_TYPE_W = 2;
    localparam int PER_ADDR_W = 12;
    localparam int PER_DATA_W = 32;
    localparam int PER_STRB_W = 4;
    localparam int PER_IDX_LSB = 2;
    localparam int PER_IDX_W = 5;
    // ==========================================
    // register map
    localparam logic [11:0] PER_CFG_BASE = 12'h000;
    localparam logic [11:0] PER_STATUS_ADDR = 12'h080;
    // ==========================================
    // channel config word fields
    localparam int PER_CFG_W = 6;
    localparam int PER_STAT_BIT = 6;
    localparam int PER_SW_BIT = 8;
    localparam int PER_CFG_LANE = 0;
    localparam int PER_SW_LANE = 1;
    // ==========================================
    // bus responses
    localparam logic [1:0] PER_RESP_OKAY = 2'h0;
    localparam logic [1:0] PER_RESP_SLVERR = 2'h2;
    // ==========================================
    // types
    typedef struct packed {
        logic async;
        logic [PER_TYPE_W-1:0] rtype;
        logic [PER_SEL_W-1:0] sel;
        logic en;
    } per_cfg_type;
    localparam per_cfg_type PER_CFG_RST = '0;
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
        logic prev;
    } per_cond_type;
endpackage
`default_nettype wire

// ==== verilog/per_event_cond.sv ====
// edge detection for one peripheral event, direct and synchronised paths
`default_nettype none
module per_event_cond (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic evt,
    output logic direct_rise,
    output logic sync_rise
);
    import per_pkg::*;
    per_cond_type q;
    per_cond_type d;
    // ==========================================
    // next state
    always_comb begin
        d = q;
        d.s1 = evt;
        d.s2 = q.s1;
        d.s3 = q.s2;
        if (q.s2 == q.s3) begin
            d.lvl = q.s3;
        end
        d.prev = evt;
    end
    // ==========================================
    // registers
    always_ff @(posedge core_clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
    // same-domain edge, no added wait
    assign direct_rise = evt & ~q.prev;
    // foreign-domain edge after three-stage filter
    assign sync_rise = (q.s2 == q.s3) & q.s3 & ~q.lvl;
endmodule
`default_nettype wire

// ==== verification/per_dma_model.sv ====
// behavioural dma controller answering requests with acknowledges
`default_nettype none
module per_dma_model (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [31:0] dma_req,
    input wire logic [7:0] dly,
    output logic [31:0] dma_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt [32];
    // ==========================================
    // one ack pulse per request after dly cycles
    always @(posedge core_clk) begin
        for (int c = 0; c < 32; c++) begin
            if (srst || !dma_req[c] || dma_ack[c]) begin
                dma_ack[c] <= 1'b0;
                cnt[c] <= 0;
            end else if (cnt[c] >= dly) begin
                dma_ack[c] <= 1'b1;
            end else begin
                cnt[c] <= cnt[c] + 1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// self-checking bench for the event router
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import per_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [127:0] evt_in = '0;
    logic [31:0] dma_ack, dma_req, s_axi_rdata;
    logic [31:0] s_axi_wdata = '0;
    logic [31:0] dma_req_dir, dma_ack_dir;
    logic [15:0] timer_trig_dir;
    logic [63:0] dma_req_type;
    logic [15:0] timer_trig;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] dly = 8'h00;
    int n_fail = 0;
    int checks = 0;
    int cfg_m [32];
    per_router_top i_per_router_top (.core_clk, .srst, .evt_in, .dma_ack, .dma_req, .dma_req_type, .timer_trig,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    per_dma_model i_per_dma_model (.core_clk, .srst, .dma_req, .dly, .dma_ack);
    // direct variant sharing the register bus, so its config mirrors the muxed one
    per_router_top #(.MUXED(1'b0)) i_per_router_top_dir (.core_clk, .srst, .evt_in, .dma_ack(dma_ack_dir),
        .dma_req(dma_req_dir), .dma_req_type(), .timer_trig(timer_trig_dir), .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(),
        .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(),
        .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready);
    per_dma_model i_per_dma_model_dir (.core_clk, .srst, .dma_req(dma_req_dir), .dly, .dma_ack(dma_ack_dir));
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    // ==========================================
    // reporting
    task test_done();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task timeout();
        n_fail++;
        $display("[ERR] %0t wait ran out", $time);
        test_done();
    endtask
    task chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // ==========================================
    // axi4-lite master
    task axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] st, output logic [1:0] r);
        int i;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (r === PER_RESP_OKAY && st[0] && a < 12'h080) cfg_m[a[6:2]] = d[5:0];
        if (i == 100) timeout();
    endtask
    task axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int i;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (i == 100) timeout();
    endtask
    task wait_req(input int c, input logic v, output int n);
        n = 0;
        #1;
        while (dma_req[c] !== v && n < 50) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n == 50) timeout();
    endtask
    // ==========================================
    // main sequence
    initial begin
        int c, s, t, n;
        logic [1:0] r;
        logic [31:0] d;
        c = $urandom(32'h8e01);
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk(dma_req, 0);
        axi_rd(PER_CFG_BASE, d, r);
        chk(d, 0);
        $display("test reset done");
        dly <= 8'd20;
        for (s = 0; s < 4; s++) begin
            c = $urandom_range(31);
            t = $urandom_range(3);
            axi_wr(12'(c * 4), 32'(t * 8 + s * 2 + 1), 4'h1, r);
            chk(r, PER_RESP_OKAY);
            @(posedge core_clk);
            evt_in[c * 4 + (s + 1) % 4] <= 1'b1;
            repeat (2) @(posedge core_clk);
            #1;
            chk(dma_req, 0);
            @(posedge core_clk);
            evt_in[c * 4 + s] <= 1'b1;
            @(posedge core_clk);
            #1;
            chk(dma_req, 32'h1 << c);
            chk(timer_trig, c < 16 ? 16'h1 << c : 16'h0);
            chk(dma_req_type[2 * c +: 2], t);
            @(posedge core_clk);
            #1;
            chk(timer_trig, 0);
            axi_rd(PER_STATUS_ADDR, d, r);
            chk(d, 32'h1 << c);
            axi_rd(12'(c * 4), d, r);
            chk(r, PER_RESP_OKAY);
            chk(d, cfg_m[c] | 64);
            wait_req(c, 1'b0, n);
            chk(dma_ack, 0);
            evt_in <= '0;
            axi_wr(12'(c * 4), 32'h0, 4'h1, r);
        end
        $display("test select done");
        dly <= 8'd0;
        repeat (8) begin
            @(posedge core_clk);
            evt_in <= {$urandom, $urandom, $urandom, $urandom};
            #1;
            chk(dma_req, 0);
        end
        evt_in <= '0;
        $display("test disabled done");
        c = $urandom_range(31);
        axi_wr(12'(c * 4), 32'h21, 4'h1, r);
        @(posedge core_clk);
        evt_in[c * 4] <= 1'b1;
        @(posedge core_clk);
        #1;
        chk(dma_req[c], 0);
        wait_req(c, 1'b1, n);
        chk(n < 8, 1);
        wait_req(c, 1'b0, n);
        evt_in <= '0;
        $display("test async done");
        axi_wr(12'(c * 4), 32'h101, 4'h3, r);
        wait_req(c, 1'b1, n);
        chk(dma_req, 32'h1 << c);
        wait_req(c, 1'b0, n);
        $display("test soft event done");
        @(posedge core_clk);
        evt_in[c] <= 1'b1;
        @(posedge core_clk);
        #1;
        chk(dma_req_dir, 32'h1 << c);
        chk(dma_req, c == 0 ? 32'h1 : 32'h0);
        chk(timer_trig_dir, 0);
        $display("test direct done");
        axi_wr(12'h084, 32'h1, 4'h1, r);
        chk(r, PER_RESP_SLVERR);
        axi_wr(PER_STATUS_ADDR, 32'h1, 4'h1, r);
        chk(r, PER_RESP_SLVERR);
        axi_rd(12'h0fc, d, r);
        chk({r, d}, {PER_RESP_SLVERR, 32'h0});
        $display("test unmapped done");
        test_done();
    end
endmodule
`default_nettype wire
